// *** logic/sfc_pkg.sv ***
// Shared constants and carrier types for the self-programming flash controller
package sfc_pkg;
  // Control/status register index; byte address is four times it
  localparam logic [11:0] CSR_IDX = 12'h037;
  localparam logic [11:0] CSR_ADDR = 12'h0dc;
  localparam logic [7:0] CSR_RESET = 8'h00;
  // Field positions
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_REEN = 4;
  localparam int BIT_LOCK = 3;
  localparam int BIT_PGWR = 2;
  localparam int BIT_PGER = 1;
  localparam int BIT_WIN = 0;
  // Accepted low-five-bit command patterns
  localparam logic [4:0] CMD_FILL = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_REEN = 5'h11;
  // Window lengths in clock cycles
  localparam logic [2:0] WIN_CYCLES = 3'h4;
  localparam logic [2:0] LPM_CYCLES = 3'h3;
  // Flash geometry
  localparam int PC_W = 14;
  localparam int WORD_W = 6;
  localparam int PAGE_W = 8;
  localparam logic [13:0] LIVE_LIMIT = 14'h3800;
  localparam logic [7:0] LIVE_PAGES = 8'he0;
  localparam logic [13:0] BOOT_256 = 14'h3f00;
  localparam logic [13:0] BOOT_512 = 14'h3e00;
  localparam logic [13:0] BOOT_1K = 14'h3c00;
  localparam logic [13:0] BOOT_2K = 14'h3800;
  localparam logic [7:0] LOCK_RESET = 8'hff;
  localparam logic [15:0] BLANK_WORD = 16'hffff;
  // Erase/write time and its cycle count at 200 MHz
  localparam int PROG_TIME_NS = 3700000;
  localparam int CLK_NS = 5;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int OP_W = 20;

  // Store-program instruction operands from the core
  typedef struct packed {
    logic [15:0] z;
    logic [7:0] r1;
    logic [7:0] r0;
  } sfc_spm_req_t;

  // Command to the flash array
  typedef struct packed {
    logic erase;
    logic write;
    logic [7:0] page;
  } sfc_flash_cmd_t;
endpackage : sfc_pkg

// *** logic/sfc_self_program_ctrl.sv ***
// Self-programming flash controller: control register, windows, page buffer
//
// How it works
// - Boot-size fuses pick boot section start
// - Words below 0x3800 form the live section
// - Flash words addressed by 14-bit counter
// - Word index from pointer bits 6..1
// - Page select from pointer bits 14..7
// - Ready irq while enable set, window closed
// - Live erase/write sets busy, blocks fetches
// - Busy clears on re-enable or buffer load
// - Re-enable store restores live section access
// - Re-enable ignored while erase/write runs
// - Re-enable during loading discards buffer
// - Lock store programs lock bits from r0
// - Lock-set clears on completion or timeout
// - Load within three cycles reads lock/fuse
// - Plain window stores r1:r0 into buffer
// - Page-write store writes buffer to page
// - Page-erase store erases page, may halt
// - Only five command patterns take effect
`timescale 1ns/1ps
`default_nettype none

module sfc_self_program_ctrl #(
  parameter int PROG_CYCLES = sfc_pkg::PROG_CYCLES,
  parameter int PAGE_WORDS = 64
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spm_valid,
  input wire sfc_pkg::sfc_spm_req_t spm_req,
  input wire logic lpm_valid,
  input wire logic [15:0] lpm_z,
  output logic lpm_hit,
  output logic [7:0] lpm_data,
  input wire logic global_irq_en,
  output logic spm_ready_irq,
  input wire logic [13:0] fetch_addr,
  output logic fetch_block,
  output logic cpu_halt,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic [7:0] fuse_ext,
  input wire logic boot_size_fuse_hi,
  input wire logic boot_size_fuse_lo,
  output logic [13:0] boot_start,
  output var sfc_pkg::sfc_flash_cmd_t flash_cmd,
  input wire logic [5:0] buf_rd_idx,
  output logic [15:0] buf_rd_data,
  output logic [7:0] lock_bits
);

  // True when a word address lies in the live read-while-write section
  function automatic logic in_live(input logic [13:0] a);
    in_live = a < sfc_pkg::LIVE_LIMIT;
  endfunction : in_live

  // Fuse pins are static straps but still pass two flops
  // so a strap that moves during bring-up cannot split one decode
  logic [25:0] fuse_meta_ff;
  logic [25:0] fuse_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_meta_ff <= '0;
      fuse_ff <= '0;
    end else begin
      fuse_meta_ff <= {boot_size_fuse_hi, boot_size_fuse_lo,
                       fuse_ext, fuse_high, fuse_low};
      fuse_ff <= fuse_meta_ff;
    end
  end

  wire [1:0] boot_sz = fuse_ff[25:24];
  wire [7:0] fuse_ext_s = fuse_ff[23:16];
  wire [7:0] fuse_high_s = fuse_ff[15:8];
  wire [7:0] fuse_low_s = fuse_ff[7:0];

  // Boot section start from the two size fuses
  // Settles two edges after a strap change, through the sync flops
  assign boot_start = (boot_sz == 2'b11) ? sfc_pkg::BOOT_256 :
                      (boot_sz == 2'b10) ? sfc_pkg::BOOT_512 :
                      (boot_sz == 2'b01) ? sfc_pkg::BOOT_1K :
                      sfc_pkg::BOOT_2K;

  // Control/status state
  // cmd_ff holds bits 4..0 as written; window and timer run beside it
  logic irq_en_ff;
  logic busy_ff;
  logic [4:0] cmd_ff;
  logic [2:0] win_ff;
  logic [sfc_pkg::OP_W-1:0] op_ff;
  logic halt_ff;
  logic [7:0] lock_ff;
  logic [31:0] prdata_ff;
  logic lpm_hit_ff;
  logic [7:0] lpm_data_ff;
  logic [15:0] buf_rd_ff;
  sfc_pkg::sfc_flash_cmd_t flash_cmd_ff;

  // Page buffer and per-word loaded flags
  // No reset on the array itself; the flags say which words are real
  logic [15:0] buf_mem [0:PAGE_WORDS-1];
  logic [PAGE_WORDS-1:0] buf_vld_ff;

  // Bus decode
  // Only one word is mapped; every other address answers with an error
  wire hit_csr = paddr == sfc_pkg::CSR_ADDR;
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire csr_wr = access && pwrite && hit_csr;

  // Operation in progress keeps the enable bit high
  // While it runs, cmd_ff keeps the command so the enable bit reads one
  wire op_busy = op_ff != '0;
  wire win_open = win_ff != 3'h0;
  wire [4:0] wcmd = pwdata[4:0];

  // Only the five command patterns are taken
  // Anything else is dropped whole, so half a command never arms
  wire cmd_legal = (wcmd == sfc_pkg::CMD_FILL) ||
                   (wcmd == sfc_pkg::CMD_ERASE) ||
                   (wcmd == sfc_pkg::CMD_WRITE) ||
                   (wcmd == sfc_pkg::CMD_LOCK) ||
                   (wcmd == sfc_pkg::CMD_REEN);

  // Writes during a running erase/write cannot open a window
  // A re-enable sent too early is lost; software must poll the enable bit
  wire cmd_take = csr_wr && cmd_legal && !op_busy;
  wire reen_wr = cmd_take && (wcmd == sfc_pkg::CMD_REEN);

  // Store decode; nothing happens with the window shut
  // A store with no window open is simply ignored here
  wire spm_go = spm_valid && win_open && !op_busy;
  wire do_fill = spm_go && (cmd_ff == sfc_pkg::CMD_FILL);
  wire do_erase = spm_go && (cmd_ff == sfc_pkg::CMD_ERASE);
  wire do_write = spm_go && (cmd_ff == sfc_pkg::CMD_WRITE);
  wire do_lock = spm_go && (cmd_ff == sfc_pkg::CMD_LOCK);
  wire do_reen = spm_go && (cmd_ff == sfc_pkg::CMD_REEN);
  wire do_prog = do_erase || do_write;

  // Pointer fields
  // Bit 0 of the pointer plays no part in store addressing
  wire [5:0] word_select_field = spm_req.z[6:1];
  wire [7:0] page_select_field = spm_req.z[14:7];
  wire page_live = in_live({page_select_field, 6'h00});

  // Load within three cycles of a lock-set window
  // Counter values 4, 3 and 2 are the first three edges after the write
  wire lpm_go = lpm_valid && (cmd_ff == sfc_pkg::CMD_LOCK) &&
                (win_ff >= 3'h2);
  wire [7:0] lpm_sel = (lpm_z[1:0] == 2'b00) ? fuse_low_s :
                       (lpm_z[1:0] == 2'b01) ? lock_ff :
                       (lpm_z[1:0] == 2'b10) ? fuse_ext_s :
                       fuse_high_s;

  // Window ends on timeout or on a completed short command
  // A store on the last window edge still counts before the close
  wire win_last = win_ff == 3'h1;
  wire short_done = do_fill || do_lock || do_reen || lpm_go;
  wire op_done = op_ff == {{(sfc_pkg::OP_W-1){1'b0}}, 1'b1};

  // Register image; reserved bit reads zero
  // Busy and irq enable sit beside the command bits
  wire [7:0] csr_rd = {irq_en_ff, busy_ff, 1'b0, cmd_ff};

  // Interrupt enable: any write updates it, command legal or not
  // It lives outside the command, so a running erase does not lock it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_ff <= sfc_pkg::CSR_RESET[sfc_pkg::BIT_IRQ_EN];
    end else if (csr_wr) begin
      irq_en_ff <= pwdata[sfc_pkg::BIT_IRQ_EN];
    end
  end

  // Command bits and the four-cycle window counter
  // Priority: new command, then erase/write start, then the running timer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff <= sfc_pkg::CSR_RESET[4:0];
      win_ff <= 3'h0;
    end else if (cmd_take) begin
      cmd_ff <= wcmd;
      win_ff <= sfc_pkg::WIN_CYCLES;
    end else if (do_prog) begin
      win_ff <= 3'h0; // Bits stay set until the array is done
    end else if (op_busy) begin
      if (op_done) begin
        cmd_ff <= 5'h00;
      end
    end else if (short_done || win_last) begin
      cmd_ff <= 5'h00;
      win_ff <= 3'h0;
    end else if (win_open) begin
      win_ff <= win_ff - 3'h1;
    end
  end

  // Erase/write timer; cycle count truncated to the counter width
  // A short count in simulation keeps runs brief; the array is not modelled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_ff <= '0;
    end else if (do_prog) begin
      op_ff <= sfc_pkg::OP_W'(PROG_CYCLES);
    end else if (op_busy) begin
      op_ff <= op_ff - {{(sfc_pkg::OP_W-1){1'b0}}, 1'b1};
    end
  end

  // Halt the core while the halting section is being changed
  // Live-section pages never halt; they raise busy instead
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_ff <= 1'b0;
    end else if (do_prog) begin
      halt_ff <= !page_live;
    end else if (op_done) begin
      halt_ff <= 1'b0;
    end
  end

  // Busy: set beats clear when both land in one cycle
  // Busy is the only thing that keeps live fetches stalled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= sfc_pkg::CSR_RESET[sfc_pkg::BIT_BUSY];
    end else if (do_prog && page_live) begin
      busy_ff <= 1'b1;
    end else if (do_reen || do_fill) begin
      busy_ff <= 1'b0;
    end
  end

  // Lock bits only move towards programmed (zero); top two stay one
  // Only reset, which loads LOCK_RESET, brings them back; chip erase is not part of this block
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_ff <= sfc_pkg::LOCK_RESET;
    end else if (do_lock) begin
      lock_ff <= lock_ff & {2'b11, spm_req.r0[5:0]};
    end
  end

  // Buffer fill; r1 and r0 pair form one word
  // No reset here, so the array maps onto plain memory
  always_ff @(posedge core_clk) begin
    if (do_fill) begin
      buf_mem[word_select_field] <= {spm_req.r1, spm_req.r0};
    end
  end

  // Loaded flags: re-enable write or finished page write discards data
  // Clear wins over a fill in the same cycle: the load is being aborted
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_vld_ff <= '0;
    end else if (reen_wr) begin
      buf_vld_ff <= '0;
    end else if (op_done && cmd_ff == sfc_pkg::CMD_WRITE) begin
      buf_vld_ff <= '0;
    end else if (do_fill) begin
      buf_vld_ff[word_select_field] <= 1'b1;
    end
  end

  // Array read port for the page write; unloaded words read blank
  // One cycle of latency so the read port can stay a plain memory read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_rd_ff <= sfc_pkg::BLANK_WORD;
    end else begin
      buf_rd_ff <= buf_vld_ff[buf_rd_idx] ? buf_mem[buf_rd_idx] :
                   sfc_pkg::BLANK_WORD;
    end
  end

  // One-cycle command to the array with the selected page
  // Page holds after the pulse, for an array that samples it late
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_cmd_ff <= '0;
    end else begin
      flash_cmd_ff.erase <= do_erase;
      flash_cmd_ff.write <= do_write;
      flash_cmd_ff.page <= do_prog ? page_select_field :
                           flash_cmd_ff.page;
    end
  end

  // Lock/fuse read-back, answered the cycle after the load
  // Data holds until the next accepted load
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lpm_hit_ff <= 1'b0;
      lpm_data_ff <= 8'h00;
    end else begin
      lpm_hit_ff <= lpm_go;
      lpm_data_ff <= lpm_go ? lpm_sel : lpm_data_ff;
    end
  end

  // Read data captured in setup so it comes from a flop
  // The cost: a read shows the register as it stood at the setup edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      prdata_ff <= hit_csr ? {24'h00_0000, csr_rd} : 32'h0000_0000;
    end
  end

  // APB answer: no wait states, error on unmapped addresses
  // Back-to-back transfers are taken without an idle cycle
  assign pready = access;
  assign pslverr = access && !hit_csr;
  assign prdata = prdata_ff;

  // Ready interrupt is a level while no window is open
  // It stays up as long as both enables hold and the enable bit is clear
  assign spm_ready_irq = irq_en_ff && global_irq_en &&
                         !cmd_ff[sfc_pkg::BIT_WIN];

  // Live section fetches stall while busy
  // Boot-space fetches are never stalled by this block
  assign fetch_block = busy_ff && in_live(fetch_addr);
  assign cpu_halt = halt_ff;
  assign flash_cmd = flash_cmd_ff;
  assign buf_rd_data = buf_rd_ff;
  assign lock_bits = lock_ff;
  assign lpm_hit = lpm_hit_ff;
  assign lpm_data = lpm_data_ff;

endmodule : sfc_self_program_ctrl

`default_nettype wire

// *** test/sfc_core_model.sv ***
// Behavioural core issuing store-program and load-program instructions
`timescale 1ns/1ps
`default_nettype none
module sfc_core_model (
  input wire logic core_clk,
  output logic spm_valid,
  output var sfc_pkg::sfc_spm_req_t spm_req,
  output logic lpm_valid,
  output logic [15:0] lpm_z
);
  // Idle state at time zero
  initial begin
    spm_valid = 1'b0;
    lpm_valid = 1'b0;
    spm_req = 32'h0;
    lpm_z = 16'h0000;
  end
  // One store; operands are scrambled afterwards so stale values never look valid
  task automatic spm(input logic [15:0] z, input logic [7:0] r1, input logic [7:0] r0);
    spm_valid <= 1'b1;
    spm_req <= {z[15:1], 1'b0, r1, r0};
    @(posedge core_clk);
    spm_valid <= 1'b0;
    spm_req <= ~spm_req;
  endtask : spm
  // One load of the lock or fuse byte picked by the pointer
  task automatic lpm(input logic [15:0] z);
    lpm_valid <= 1'b1;
    lpm_z <= z;
    @(posedge core_clk);
    lpm_valid <= 1'b0;
    lpm_z <= ~lpm_z;
  endtask : lpm
endmodule : sfc_core_model
`default_nettype wire

// *** test/sfc_props.sv ***
// Port checker for the self-programming flash controller
`timescale 1ns/1ps
`default_nettype none
module sfc_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic spm_valid,
  input wire sfc_pkg::sfc_spm_req_t spm_req,
  input wire logic lpm_valid,
  input wire logic [15:0] lpm_z,
  input wire logic lpm_hit,
  input wire logic [7:0] lpm_data,
  input wire logic global_irq_en,
  input wire logic spm_ready_irq,
  input wire logic [13:0] fetch_addr,
  input wire logic fetch_block,
  input wire logic cpu_halt,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic [7:0] fuse_ext,
  input wire logic boot_size_fuse_hi,
  input wire logic boot_size_fuse_lo,
  input wire logic [13:0] boot_start,
  input wire sfc_pkg::sfc_flash_cmd_t flash_cmd,
  input wire logic [7:0] lock_bits
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Named slices, so that $past only ever sees plain signals
  wire op_pulse = flash_cmd.erase || flash_cmd.write;
  wire [7:0] spm_page = spm_req.z[14:7];
  wire [1:0] sel = lpm_z[1:0];
  wire [7:0] pick = sel == 2'h0 ? fuse_low : sel == 2'h1 ? lock_bits : sel == 2'h2 ? fuse_ext : fuse_high;
  wire [1:0] bsz = {boot_size_fuse_hi, boot_size_fuse_lo};

  property p_rd; psel && penable && !pwrite |->
    prdata[31:8] == 24'h0 && !prdata[5] && (!pslverr || !prdata); endproperty
  a_rd: assert property (p_rd) else $error("read data");
  property p_apb; psel && penable |-> pready && pslverr == (paddr != sfc_pkg::CSR_ADDR); endproperty
  a_apb: assert property (p_apb) else $error("apb answer");
  property p_irq; spm_ready_irq |-> global_irq_en && !cpu_halt; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_fetch; fetch_block |-> fetch_addr < sfc_pkg::LIVE_LIMIT; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch block");
  // Fuses pass two sync flops, so three quiet edges settle the decode
  property p_boot; $stable(bsz) [*3] |-> boot_start == (bsz[1] ? (bsz[0] ? 14'h3f00 : 14'h3e00) :
    (bsz[0] ? 14'h3c00 : 14'h3800)); endproperty
  a_boot: assert property (p_boot) else $error("boot start");
  property p_cmd; $rose(op_pulse) |-> ($past(spm_valid) && flash_cmd.page == $past(spm_page)) ||
    ($past(spm_valid, 2) && flash_cmd.page == $past(spm_page, 2)); endproperty
  a_cmd: assert property (p_cmd) else $error("flash page");
  property p_pulse; op_pulse |=> !op_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("cmd pulse");
  property p_halt; op_pulse && flash_cmd.page >= sfc_pkg::LIVE_PAGES |-> ##[0:2] cpu_halt; endproperty
  a_halt: assert property (p_halt) else $error("halt");
  property p_lpm; lpm_hit |-> $past(lpm_valid) && lpm_data == $past(pick); endproperty
  a_lpm: assert property (p_lpm) else $error("lock read");
  property p_lock; lock_bits[7:6] == 2'b11 && !(lock_bits & ~$past(lock_bits)); endproperty
  a_lock: assert property (p_lock) else $error("lock bits");
endmodule : sfc_props
bind sfc_self_program_ctrl sfc_props u_props (.*);
`default_nettype wire

// *** test/sfc_self_program_ctrl_tb.sv ***
// Self-checking testbench for the self-programming flash controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t %h %h", $time, g, e); end end
module sfc_self_program_ctrl_tb;
  localparam int PROG = 40;
  localparam logic [11:0] A = sfc_pkg::CSR_ADDR;
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, global_irq_en = 1'b0;
  logic boot_size_fuse_hi = 1'b0, boot_size_fuse_lo = 1'b0;
  logic pready, pslverr, spm_valid, lpm_valid, lpm_hit, spm_ready_irq, fetch_block, cpu_halt;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, got, mon_exp;
  logic [15:0] lpm_z, buf_rd_data, fill_data[4];
  logic [7:0] lpm_data, lock_bits, fuse_low, fuse_high, fuse_ext;
  logic [7:0] bad[5] = '{8'h07, 8'h1f, 8'h0b, 8'h02, 8'h13};
  logic [13:0] fetch_addr = 14'h3900, boot_start;
  logic [13:0] boot_tbl[4] = '{14'h3800, 14'h3c00, 14'h3e00, 14'h3f00};
  logic [5:0] buf_rd_idx = 6'h00, fill_idx[4] = '{6'h00, 6'h01, 6'h3e, 6'h3f};
  sfc_pkg::sfc_spm_req_t spm_req;
  sfc_pkg::sfc_flash_cmd_t flash_cmd;
  int error_cnt = 0, check_count = 0;
  logic [31:0] exp_q[$];
  logic [9:0] cmd_q[$];
  logic [9:0] mon_cmd;

  sfc_self_program_ctrl #(.PROG_CYCLES(PROG)) u_dut (.core_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .spm_valid, .spm_req, .lpm_valid, .lpm_z, .lpm_hit, .lpm_data, .global_irq_en,
    .spm_ready_irq, .fetch_addr, .fetch_block, .cpu_halt, .fuse_low, .fuse_high, .fuse_ext, .boot_size_fuse_hi,
    .boot_size_fuse_lo, .boot_start, .flash_cmd, .buf_rd_idx, .buf_rd_data, .lock_bits);
  sfc_core_model u_core (.core_clk, .spm_valid, .spm_req, .lpm_valid, .lpm_z);

  // 200 MHz clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // One APB transfer; a read notes its expected data at setup
  task automatic apb(input logic wr, input logic [7:0] d, input logic [7:0] e, input logic [11:0] a = A);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, 24'h0, d};
    if (!wr) exp_q.push_back({24'h0, e});
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic w(input logic [7:0] d);
    apb(1'b1, d, 8'h00);
  endtask : w
  task automatic r(input logic [7:0] e);
    apb(1'b0, 8'h00, e);
  endtask : r
  task automatic check_buf(input logic [5:0] i, input logic [15:0] e);
    @(posedge core_clk);
    buf_rd_idx <= i;
    @(posedge core_clk);
    #1 `CHK(buf_rd_data, e)
  endtask : check_buf
  task automatic print_verdict();
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // Results are taken in arrival order against the oldest note
  always @(posedge core_clk) begin
    if ((psel && penable && pready && !pwrite) === 1'b1 || lpm_hit === 1'b1) begin
      mon_exp = exp_q.size() ? exp_q.pop_front() : 'x;
      got = lpm_hit === 1'b1 ? {24'h0, lpm_data} : prdata;
      `CHK(got, mon_exp)
    end
    if ((flash_cmd.erase || flash_cmd.write) === 1'b1) begin
      mon_cmd = cmd_q.size() ? cmd_q.pop_front() : 'x;
      `CHK(flash_cmd, mon_cmd)
    end
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h61fa0af7));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    fuse_low <= 8'($urandom);
    fuse_high <= 8'($urandom);
    fuse_ext <= 8'($urandom);
    r(8'h00);
    apb(1'b0, 8'h00, 8'h00, 12'h0d8);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      {boot_size_fuse_hi, boot_size_fuse_lo} <= 2'(i);
      repeat (4) @(posedge core_clk);
      #1 `CHK(boot_start, boot_tbl[i])
    end
    // Buffer fill at both ends of the page, then a lapsed window and a stray store
    for (int i = 0; i < 4; i++) begin
      fill_data[i] = 16'($urandom);
      w(8'h01);
      u_core.spm({9'h000, fill_idx[i], 1'b0}, fill_data[i][15:8], fill_data[i][7:0]);
    end
    w(8'h01);
    repeat (6) @(posedge core_clk);
    r(8'h00);
    u_core.spm(16'h0002, 8'h5a, 8'ha5);
    for (int i = 0; i < 4; i++) check_buf(fill_idx[i], fill_data[i]);
    w(8'h11);
    u_core.spm(16'h0000, 8'h00, 8'h00);
    check_buf(6'h01, 16'hffff);
    // Erase, then write, of a live page; busy cleared by re-enable, then by a fill
    for (int j = 0; j < 2; j++) begin
      w(j ? 8'h05 : 8'h03);
      global_irq_en <= 1'b1;
      fetch_addr <= 14'h3900;
      cmd_q.push_back(j ? 10'h105 : 10'h205);
      u_core.spm({1'b0, 8'h05, 7'h00}, 8'h00, 8'h00);
      r(j ? 8'h45 : 8'h43);
      #1 `CHK(fetch_block, 1'b0)
      w(8'h11);
      r(j ? 8'h45 : 8'h43);
      repeat (PROG) @(posedge core_clk);
      fetch_addr <= 14'h0140;
      r(8'h40);
      #1 `CHK(fetch_block, 1'b1)
      w(j ? 8'h01 : 8'h11);
      u_core.spm(16'h0000, 8'hff, 8'hff);
      r(8'h00);
      #1 `CHK(fetch_block, 1'b0)
    end
    // Write to a boot page halts the core and leaves busy clear
    w(8'h05);
    cmd_q.push_back(10'h1f0);
    u_core.spm({1'b0, 8'hf0, 7'h00}, 8'h00, 8'h00);
    repeat (3) @(posedge core_clk);
    #1 `CHK(cpu_halt, 1'b1)
    r(8'h05);
    repeat (PROG) @(posedge core_clk);
    #1 `CHK(cpu_halt, 1'b0)
    // Lock programming, lock window lapse, then lock and fuse reads
    w(8'h09);
    u_core.spm(16'h0001, 8'h00, 8'h33);
    r(8'h00);
    #1 `CHK(lock_bits, 8'hf3)
    w(8'h09);
    repeat (6) @(posedge core_clk);
    r(8'h00);
    for (int z = 0; z < 4; z++) begin
      w(8'h09);
      exp_q.push_back({24'h0, z == 0 ? fuse_low : z == 1 ? 8'hf3 : z == 2 ? fuse_ext : fuse_high});
      u_core.lpm(16'(z));
      repeat (2) @(posedge core_clk);
    end
    // Rejected patterns, then the ready interrupt
    foreach (bad[k]) begin
      w(bad[k]);
      r(8'h00);
    end
    w(8'h80);
    r(8'h80);
    #1 `CHK(spm_ready_irq, 1'b1)
    @(posedge core_clk);
    global_irq_en <= 1'b0;
    @(posedge core_clk);
    #1 `CHK(spm_ready_irq, 1'b0)
    print_verdict();
  end
endmodule : sfc_self_program_ctrl_tb
`default_nettype wire
